// >>> pkg/dtru_pkg.sv
// constants and types for the dual timer register update block
// assumes one 20 MHz clock and an 8-bit host register port
`default_nettype none

package dtru_pkg;

    // register port geometry
    localparam int DTRU_DATA_W = 8;
    localparam int DTRU_SEL_W = 3;

    // register select codes
    localparam logic [2:0] DTRU_SEL_CTRL = 3'h0;
    localparam logic [2:0] DTRU_SEL_MODE = 3'h1;
    localparam logic [2:0] DTRU_SEL_A_LOW = 3'h2;
    localparam logic [2:0] DTRU_SEL_B_LOW = 3'h3;
    localparam logic [2:0] DTRU_SEL_A_HIGH = 3'h4;
    localparam logic [2:0] DTRU_SEL_B_HIGH = 3'h5;

    // reset values
    localparam logic [7:0] DTRU_RST_CTRL = 8'h00;
    localparam logic [7:0] DTRU_RST_MODE = 8'h00;
    localparam logic [7:0] DTRU_RST_COUNT = 8'h00;
    localparam logic [7:0] DTRU_READ_UNMAPPED = 8'h00;

    // timer_ctrl field positions
    localparam int DTRU_CTRL_RUN_A = 4;
    localparam int DTRU_CTRL_FLAG_A = 5;
    localparam int DTRU_CTRL_RUN_B = 6;
    localparam int DTRU_CTRL_FLAG_B = 7;

    // timer_mode_cfg field positions
    localparam int DTRU_MODE_A_LSB = 0;
    localparam int DTRU_MODE_CT_A = 2;
    localparam int DTRU_MODE_GATE_A = 3;
    localparam int DTRU_MODE_B_LSB = 4;
    localparam int DTRU_MODE_CT_B = 6;
    localparam int DTRU_MODE_GATE_B = 7;

    // mode 0 keeps five low count bits
    localparam logic [7:0] DTRU_MODE0_LOW_MASK = 8'h1F;
    localparam logic [7:0] DTRU_COUNT_MAX = 8'hFF;

    // time base: one tick per 12 system clocks
    localparam int DTRU_PRESCALE = 12;
    localparam logic [3:0] DTRU_PRESCALE_LAST = 4'(DTRU_PRESCALE - 1);
    localparam logic [3:0] DTRU_PRESCALE_RST = 4'h0;

    // operating modes, in field order 00, 01, 10, 11
    typedef enum logic [1:0] {
        DTRU_MODE_13BIT,
        DTRU_MODE_16BIT,
        DTRU_MODE_RELOAD,
        DTRU_MODE_SPLIT
    } dtru_mode_e;

endpackage : dtru_pkg

`default_nettype wire

// >>> design/dtru_tick_src.sv
// raw count tick source for one timer: time base or external falling edge
// assumes extPulse is synchronous to clk and stable for a clock period
`default_nettype none

module dtru_tick_src (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // tick selection
    input wire logic prescaleTick,
    input wire logic counterMode,
    input wire logic extPulse,
    // result
    output logic tick
);
    import dtru_pkg::*;

    logic pulseLast;
    logic fallSeen;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pulseLast <= 1'b0;
        end else begin
            pulseLast <= extPulse;
        end
    end

    // falling edge of the external pin
    assign fallSeen = pulseLast & ~extPulse;
    assign tick = counterMode ? fallSeen : prescaleTick;

endmodule // dtru_tick_src

`default_nettype wire

// >>> design/dtru_timer.sv
// dual timer with 8-bit host register port: control, mode and four counts
// assumes host strobes and external pins are synchronous to clk
//
// Overview of operation
// - all register updates on rising clock edge
// - reset clears control, mode, four counts
// - store to select 000 writes timer_ctrl
// - store to select 001 writes timer_mode_cfg
// - select 010 writes count_a_low, mode0 masked
// - select 011 writes count_b_low, mode0 masked
// - select 100 writes whole count_a_high
// - select 101 writes whole count_b_high
// - high A overflow sets flag A, modes 0/1
// - low A overflow sets flag A, modes 0/1/3
// - flag B from B high, B low, split A
// - mode 2 reloads count_a_low from count_a_high
// - mode 2 reloads count_b_low from count_b_high
// - tick_a_low increments count_a_low, mode0 five bits
// - tick_b_low increments count_b_low, mode0 five bits
// - tick_a_high increments count_a_high
// - count_b_high counts only in modes 0,1
// - fetch strobe presents selected register
// - two-bit mode field selects operating mode
// - tick every 12 clocks or pin fall
// - ticks need run bit and gate; split high A needs run B only
// - irq_out high while any flag set
`default_nettype none

module dtru_timer (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // host register port
    input wire logic [dtru_pkg::DTRU_SEL_W-1:0] regSelect,
    input wire logic store_strobe,
    input wire logic fetch_strobe,
    input wire logic [dtru_pkg::DTRU_DATA_W-1:0] host_write_bus,
    output logic [dtru_pkg::DTRU_DATA_W-1:0] host_read_bus,
    // external timer pins
    input wire logic ext_pulse_a,
    input wire logic ext_pulse_b,
    input wire logic ext_enable_a,
    input wire logic ext_enable_b,
    // interrupt
    output logic irq_out
);
    import dtru_pkg::*;

    // registers
    logic [7:0] timerCtrl;
    logic [7:0] timerModeCfg;
    logic [7:0] countALow;
    logic [7:0] countBLow;
    logic [7:0] countAHigh;
    logic [7:0] countBHigh;
    logic [7:0] readData;
    logic [3:0] prescaleCount;

    // next values
    logic [7:0] next_timerCtrl;
    logic [7:0] next_countALow;
    logic [7:0] next_countBLow;
    logic [7:0] next_countAHigh;
    logic [7:0] next_countBHigh;
    logic [3:0] next_prescaleCount;

    // register field views
    dtru_mode_e modeA;
    dtru_mode_e modeB;
    logic runA;
    logic runB;
    logic flagA;
    logic flagB;
    logic counterModeA;
    logic counterModeB;
    logic gateSelA;
    logic gateSelB;

    assign modeA = dtru_mode_e'(timerModeCfg[DTRU_MODE_A_LSB +: 2]);
    assign modeB = dtru_mode_e'(timerModeCfg[DTRU_MODE_B_LSB +: 2]);
    assign counterModeA = timerModeCfg[DTRU_MODE_CT_A];
    assign counterModeB = timerModeCfg[DTRU_MODE_CT_B];
    assign gateSelA = timerModeCfg[DTRU_MODE_GATE_A];
    assign gateSelB = timerModeCfg[DTRU_MODE_GATE_B];
    assign runA = timerCtrl[DTRU_CTRL_RUN_A];
    assign runB = timerCtrl[DTRU_CTRL_RUN_B];
    assign flagA = timerCtrl[DTRU_CTRL_FLAG_A];
    assign flagB = timerCtrl[DTRU_CTRL_FLAG_B];

    // host store decode
    logic storeCtrl;
    logic storeMode;
    logic storeALow;
    logic storeBLow;
    logic storeAHigh;
    logic storeBHigh;

    assign storeCtrl = store_strobe && (regSelect == DTRU_SEL_CTRL);
    assign storeMode = store_strobe && (regSelect == DTRU_SEL_MODE);
    assign storeALow = store_strobe && (regSelect == DTRU_SEL_A_LOW);
    assign storeBLow = store_strobe && (regSelect == DTRU_SEL_B_LOW);
    assign storeAHigh = store_strobe && (regSelect == DTRU_SEL_A_HIGH);
    assign storeBHigh = store_strobe && (regSelect == DTRU_SEL_B_HIGH);

    // mode 0 drops the top three bits of a low-byte store
    logic [7:0] hostLowA;
    logic [7:0] hostLowB;

    assign hostLowA = (modeA == DTRU_MODE_13BIT) ?
                      (host_write_bus & DTRU_MODE0_LOW_MASK) : host_write_bus;
    assign hostLowB = (modeB == DTRU_MODE_13BIT) ?
                      (host_write_bus & DTRU_MODE0_LOW_MASK) : host_write_bus;

    // shared divide-by-12 time base
    logic prescaleTick;

    assign prescaleTick = (prescaleCount == DTRU_PRESCALE_LAST);
    assign next_prescaleCount = prescaleTick ? DTRU_PRESCALE_RST :
                                4'(prescaleCount + 4'h1);

    // raw ticks before run and gate qualification
    logic rawTickA;
    logic rawTickB;

    dtru_tick_src tickSrcA (
        .clk(clk),
        .reset(reset),
        .prescaleTick(prescaleTick),
        .counterMode(counterModeA),
        .extPulse(ext_pulse_a),
        .tick(rawTickA)
    );

    dtru_tick_src tickSrcB (
        .clk(clk),
        .reset(reset),
        .prescaleTick(prescaleTick),
        .counterMode(counterModeB),
        .extPulse(ext_pulse_b),
        .tick(rawTickB)
    );

    // run and gate enables
    logic enableA;
    logic enableB;
    logic stopB;

    assign enableA = runA && (!gateSelA || ext_enable_a);
    assign enableB = runB && (!gateSelB || ext_enable_b);
    // timer B in mode 3 is held still
    assign stopB = (modeB == DTRU_MODE_SPLIT);

    // low-byte ticks
    logic tick_a_low;
    logic tick_b_low;

    assign tick_a_low = rawTickA && enableA;
    assign tick_b_low = rawTickB && enableB && !stopB;

    // low-byte overflow: five bits in mode 0, eight otherwise
    logic lowFullA;
    logic lowFullB;
    logic lowOvfA;
    logic lowOvfB;

    assign lowFullA = (modeA == DTRU_MODE_13BIT) ?
                      (countALow[4:0] == DTRU_MODE0_LOW_MASK[4:0]) :
                      (countALow == DTRU_COUNT_MAX);
    assign lowFullB = (modeB == DTRU_MODE_13BIT) ?
                      (countBLow[4:0] == DTRU_MODE0_LOW_MASK[4:0]) :
                      (countBLow == DTRU_COUNT_MAX);
    assign lowOvfA = tick_a_low && lowFullA;
    assign lowOvfB = tick_b_low && lowFullB;

    // mode flags
    logic cascadeA;
    logic cascadeB;
    logic reloadA;
    logic reloadB;
    logic splitA;

    assign cascadeA = (modeA == DTRU_MODE_13BIT) || (modeA == DTRU_MODE_16BIT);
    assign cascadeB = (modeB == DTRU_MODE_13BIT) || (modeB == DTRU_MODE_16BIT);
    assign reloadA = (modeA == DTRU_MODE_RELOAD);
    assign reloadB = (modeB == DTRU_MODE_RELOAD);
    assign splitA = (modeA == DTRU_MODE_SPLIT);

    // high-byte ticks
    logic tick_a_high;
    logic tick_b_high;

    assign tick_a_high = (cascadeA && lowOvfA) ||
                         (splitA && prescaleTick && runB);
    assign tick_b_high = cascadeB && lowOvfB;

    // high-byte overflow
    logic highOvfA;
    logic highOvfB;

    assign highOvfA = tick_a_high && (countAHigh == DTRU_COUNT_MAX);
    assign highOvfB = tick_b_high && (countBHigh == DTRU_COUNT_MAX);

    // overflow flag set terms
    logic setFlagA;
    logic setFlagB;

    assign setFlagA = (cascadeA && highOvfA) ||
                      (cascadeA && lowOvfA) ||
                      (splitA && lowOvfA);
    assign setFlagB = (cascadeB && highOvfB) ||
                      (reloadB && lowOvfB) ||
                      (splitA && highOvfA);

    // timer_ctrl: host store, then flags set on top so no event is lost
    always_comb begin
        next_timerCtrl = timerCtrl;
        if (storeCtrl) begin
            next_timerCtrl = host_write_bus;
        end
        if (setFlagA) begin
            next_timerCtrl[DTRU_CTRL_FLAG_A] = 1'b1;
        end
        if (setFlagB) begin
            next_timerCtrl[DTRU_CTRL_FLAG_B] = 1'b1;
        end
    end

    // count_a_low: store, reload, increment
    always_comb begin
        next_countALow = countALow;
        if (storeALow) begin
            next_countALow = hostLowA;
        end else if (reloadA && lowOvfA) begin
            next_countALow = countAHigh;
        end else if (tick_a_low) begin
            if (modeA == DTRU_MODE_13BIT) begin
                next_countALow = {3'h0, 5'(countALow[4:0] + 5'h01)};
            end else begin
                next_countALow = 8'(countALow + 8'h01);
            end
        end
    end

    // count_b_low: store, reload, increment
    always_comb begin
        next_countBLow = countBLow;
        if (storeBLow) begin
            next_countBLow = hostLowB;
        end else if (reloadB && lowOvfB) begin
            next_countBLow = countBHigh;
        end else if (tick_b_low) begin
            if (modeB == DTRU_MODE_13BIT) begin
                next_countBLow = {3'h0, 5'(countBLow[4:0] + 5'h01)};
            end else begin
                next_countBLow = 8'(countBLow + 8'h01);
            end
        end
    end

    // count_a_high: store or increment
    always_comb begin
        next_countAHigh = countAHigh;
        if (storeAHigh) begin
            next_countAHigh = host_write_bus;
        end else if (tick_a_high) begin
            next_countAHigh = 8'(countAHigh + 8'h01);
        end
    end

    // count_b_high: store, or increment in modes 0 and 1 only
    always_comb begin
        next_countBHigh = countBHigh;
        if (storeBHigh) begin
            next_countBHigh = host_write_bus;
        end else if (tick_b_high && !reloadB) begin
            next_countBHigh = 8'(countBHigh + 8'h01);
        end
    end

    // read selection
    logic [7:0] readSelect;

    assign readSelect = (regSelect == DTRU_SEL_CTRL) ? timerCtrl :
                        (regSelect == DTRU_SEL_MODE) ? timerModeCfg :
                        (regSelect == DTRU_SEL_A_LOW) ? countALow :
                        (regSelect == DTRU_SEL_B_LOW) ? countBLow :
                        (regSelect == DTRU_SEL_A_HIGH) ? countAHigh :
                        (regSelect == DTRU_SEL_B_HIGH) ? countBHigh :
                        DTRU_READ_UNMAPPED;

    // control and mode registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            timerCtrl <= DTRU_RST_CTRL;
            timerModeCfg <= DTRU_RST_MODE;
        end else begin
            timerCtrl <= next_timerCtrl;
            if (storeMode) begin
                timerModeCfg <= host_write_bus;
            end
        end
    end

    // timer A counts
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            countALow <= DTRU_RST_COUNT;
            countAHigh <= DTRU_RST_COUNT;
        end else begin
            countALow <= next_countALow;
            countAHigh <= next_countAHigh;
        end
    end

    // timer B counts
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            countBLow <= DTRU_RST_COUNT;
            countBHigh <= DTRU_RST_COUNT;
        end else begin
            countBLow <= next_countBLow;
            countBHigh <= next_countBHigh;
        end
    end

    // time base counter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prescaleCount <= DTRU_PRESCALE_RST;
        end else begin
            prescaleCount <= next_prescaleCount;
        end
    end

    // read data held until the next fetch
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            readData <= DTRU_READ_UNMAPPED;
        end else if (fetch_strobe) begin
            readData <= readSelect;
        end
    end

    assign host_read_bus = readData;
    assign irq_out = flagA || flagB;

endmodule // dtru_timer

`default_nettype wire

// >>> test/dtru_host.sv
// host processor model on the 8-bit register port
// one strobe cycle per transfer; idle lines carry inverted values
`default_nettype none

module dtru_host (
    // clock
    input wire logic clk,
    // register port
    output logic [dtru_pkg::DTRU_SEL_W-1:0] regSelect,
    output logic store_strobe,
    output logic fetch_strobe,
    output logic [dtru_pkg::DTRU_DATA_W-1:0] host_write_bus
);
    import dtru_pkg::*;

    initial begin
        regSelect = 3'h7;
        store_strobe = 1'b0;
        fetch_strobe = 1'b0;
        host_write_bus = 8'h00;
    end

    // select, data and strobe held across the sampling edge
    task automatic xfer(input logic wr, input logic [2:0] s, input logic [7:0] d);
        @(posedge clk);
        regSelect <= s;
        host_write_bus <= wr ? d : ~d;
        store_strobe <= wr;
        fetch_strobe <= !wr;
        @(posedge clk);
        store_strobe <= 1'b0;
        fetch_strobe <= 1'b0;
        regSelect <= ~s;
        host_write_bus <= ~d;
    endtask

    task automatic store(input logic [2:0] s, input logic [7:0] d);
        xfer(1'b1, s, d);
    endtask

    task automatic fetch(input logic [2:0] s);
        xfer(1'b0, s, host_write_bus);
    endtask
endmodule // dtru_host

`default_nettype wire

// >>> test/dtru_timer_chk.sv
// assertions on the dual timer register port
// bound to dtru_timer; shadows the host-only register contents
`default_nettype none

module dtru_timer_chk (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // host register port
    input wire logic [dtru_pkg::DTRU_SEL_W-1:0] regSelect,
    input wire logic store_strobe,
    input wire logic fetch_strobe,
    input wire logic [dtru_pkg::DTRU_DATA_W-1:0] host_write_bus,
    input wire logic [dtru_pkg::DTRU_DATA_W-1:0] host_read_bus,
    // timer pins and interrupt
    input wire logic ext_pulse_a,
    input wire logic ext_pulse_b,
    input wire logic ext_enable_a,
    input wire logic ext_enable_b,
    input wire logic irq_out
);
    import dtru_pkg::*;
    logic [7:0] ctrlShadow;
    logic [7:0] modeShadow;
    logic [7:0] highBShadow;
    logic highBFrozen;
    logic lowAClean;
    wire logic wrCtrl = store_strobe && regSelect == DTRU_SEL_CTRL;
    wire logic wrMode = store_strobe && regSelect == DTRU_SEL_MODE;
    wire logic wrLowA = store_strobe && regSelect == DTRU_SEL_A_LOW;
    wire logic wrHighB = store_strobe && regSelect == DTRU_SEL_B_HIGH;
    // count_b_high known: stored while timer B in mode 2 or 3
    wire logic next_highBFrozen = wrMode ? highBFrozen && host_write_bus[5] :
        wrHighB ? modeShadow[5] : highBFrozen;
    // count_a_low top bits known zero: stored or kept in mode 0
    wire logic next_lowAClean = wrMode ? lowAClean && host_write_bus[1:0] == 2'h0 :
        wrLowA ? modeShadow[1:0] == 2'h0 : lowAClean;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrlShadow <= 8'h00;
            modeShadow <= 8'h00;
            highBShadow <= 8'h00;
            highBFrozen <= 1'b0;
            lowAClean <= 1'b1;
        end else begin
            if (wrCtrl) ctrlShadow <= host_write_bus;
            if (wrMode) modeShadow <= host_write_bus;
            if (wrHighB) highBShadow <= host_write_bus;
            highBFrozen <= next_highBFrozen;
            lowAClean <= next_lowAClean;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_reset_clears_all: assert property ($fell(reset) |-> host_read_bus == 8'h00 && !irq_out)
        else $error("not clear after reset");
    a_read_holds: assert property (!fetch_strobe |=> $stable(host_read_bus))
        else $error("read data moved without fetch");
    a_unmapped_reads_zero: assert property (fetch_strobe && regSelect > 3'h5 |=>
        host_read_bus == DTRU_READ_UNMAPPED) else $error("unmapped read not zero");
    a_ctrl_read_back: assert property (fetch_strobe && regSelect == 3'h0 |=>
        (host_read_bus & 8'h5F) == ($past(ctrlShadow) & 8'h5F)) else $error("ctrl readback");
    a_mode_read_back: assert property (fetch_strobe && regSelect == 3'h1 |=>
        host_read_bus == $past(modeShadow)) else $error("mode readback");
    a_low_a_masked: assert property (fetch_strobe && regSelect == 3'h2 && lowAClean |=>
        host_read_bus[7:5] == 3'h0) else $error("low count A top bits set in mode 0");
    a_high_b_frozen: assert property (fetch_strobe && regSelect == 3'h5 && highBFrozen |=>
        host_read_bus == $past(highBShadow)) else $error("high count B moved");
    a_irq_matches_flags: assert property (fetch_strobe && regSelect == 3'h0 |=>
        (host_read_bus[7] | host_read_bus[5]) == $past(irq_out)) else $error("irq vs flags");

    c_irq_rises: cover property ($rose(irq_out));
    c_frozen_read: cover property (fetch_strobe && regSelect == 3'h5 && highBFrozen);
    c_masked_read: cover property (fetch_strobe && regSelect == 3'h2 && lowAClean);
endmodule // dtru_timer_chk

bind dtru_timer dtru_timer_chk u_chk (
    .clk, .reset, .regSelect, .store_strobe, .fetch_strobe, .host_write_bus,
    .host_read_bus, .ext_pulse_a, .ext_pulse_b, .ext_enable_a, .ext_enable_b, .irq_out
);

`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the dual timer register block
// host model drives the port; reads are noted and compared on the falling edge
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dtru_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic extPulseA = 1'b0;
    logic extEnableA = 1'b0;
    logic extPulseB = 1'b0;
    logic extEnableB = 1'b0;
    logic pend = 1'b0;
    logic [7:0] d;
    logic [7:0] notes[$];
    int n_errors = 0;
    int n_compared = 0;
    wire logic [2:0] regSelect;
    wire logic storeStrobe;
    wire logic fetchStrobe;
    wire logic [7:0] writeBus;
    wire logic [7:0] readBus;
    wire logic irq;

    always #25 clk = ~clk;

    dtru_host host (.clk(clk), .regSelect(regSelect), .store_strobe(storeStrobe),
        .fetch_strobe(fetchStrobe), .host_write_bus(writeBus));

    dtru_timer dut (.clk(clk), .reset(reset), .regSelect(regSelect),
        .store_strobe(storeStrobe), .fetch_strobe(fetchStrobe), .host_write_bus(writeBus),
        .host_read_bus(readBus), .ext_pulse_a(extPulseA), .ext_pulse_b(extPulseB),
        .ext_enable_a(extEnableA), .ext_enable_b(extEnableB), .irq_out(irq));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [2:0] s, input logic [7:0] e);
        notes.push_back(e);
        host.fetch(s);
    endtask

    // read data is valid the cycle after the fetch edge
    always @(posedge clk) pend <= fetchStrobe;
    always @(negedge clk) begin
        if (pend) begin
            check("read", readBus, notes.pop_front());
        end
    end

    task automatic wait_irq(input logic v);
        for (int n = 0; n < 60 && irq !== v; n++) @(negedge clk);
        check("irq", {7'h00, irq}, {7'h00, v});
    endtask

    task automatic pulse(input logic onB);
        {extPulseB, extPulseA} <= onB ? 2'h2 : 2'h1;
        repeat (3) @(posedge clk);
        {extPulseB, extPulseA} <= 2'h0;
        repeat (4) @(posedge clk);
    endtask

    task automatic read_all();
        for (int s = 0; s < 8; s++) rd(3'(s), 8'h00);
    endtask

    task automatic wrap_up();
        n_errors += notes.size();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (8000) @(posedge clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        d = 8'($urandom(29));
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        read_all();
        // every mode, all four counts, timers stopped
        for (int m = 0; m < 4; m++) begin
            d = {2'h0, 2'(m), 2'h0, 2'(m)};
            host.store(3'h1, d);
            rd(3'h1, d);
            d = 8'($urandom);
            for (int s = 2; s < 6; s++) begin
                host.store(3'(s), d);
                rd(3'(s), (m == 0 && s < 4) ? d & DTRU_MODE0_LOW_MASK : d);
            end
        end
        host.store(3'h0, 8'h0F);
        rd(3'h0, 8'h0F);
        host.store(3'h6, 8'hFF);
        rd(3'h6, 8'h00);
        // gated 16-bit timer A
        host.store(3'h1, 8'h09);
        host.store(3'h2, 8'hFE);
        host.store(3'h4, 8'hFF);
        host.store(3'h0, 8'h10);
        repeat (30) @(posedge clk);
        rd(3'h2, 8'hFE);
        extEnableA <= 1'b1;
        wait_irq(1'b1);
        rd(3'h0, 8'h30);
        rd(3'h4, 8'h00);
        host.store(3'h0, 8'h00);
        wait_irq(1'b0);
        // auto-reload on both timers, timer A sets no flag
        host.store(3'h1, 8'h22);
        host.store(3'h5, 8'hA5);
        host.store(3'h3, 8'hFF);
        host.store(3'h4, 8'h5A);
        host.store(3'h2, 8'hFF);
        host.store(3'h0, 8'h50);
        wait_irq(1'b1);
        rd(3'h3, 8'hA5);
        rd(3'h5, 8'hA5);
        rd(3'h0, 8'hD0);
        rd(3'h2, 8'h5A);
        // split timer A: low counts pin falls, high runs on the time base
        host.store(3'h0, 8'h10);
        host.store(3'h1, 8'h07);
        host.store(3'h2, 8'hFF);
        host.store(3'h4, 8'hFF);
        pulse(1'b0);
        rd(3'h0, 8'h30);
        rd(3'h4, 8'hFF);
        host.store(3'h0, 8'h40);
        pulse(1'b0);
        wait_irq(1'b1);
        rd(3'h0, 8'hC0);
        rd(3'h2, 8'h00);
        // gated counter B, then B held still in mode 3
        host.store(3'h1, 8'hD0);
        host.store(3'h3, 8'h10);
        host.store(3'h0, 8'h40);
        pulse(1'b1);
        rd(3'h3, 8'h10);
        extEnableB <= 1'b1;
        pulse(1'b1);
        rd(3'h3, 8'h11);
        host.store(3'h1, 8'hF0);
        pulse(1'b1);
        rd(3'h3, 8'h11);
        // reset in mid-run
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        read_all();
        repeat (2) @(posedge clk);
        wrap_up();
    end
endmodule // tb

`default_nettype wire
